// >>> rtl/smc_pkg.sv
// Package of constants and types shared by the sleep mode controller and its core-side end.
//
// Contract
// - Sleep only when armed and halt executes.
// - Mode codes: 000 idle, 001 noise, 010 down.
// - Register bits: 7 sel2, 6 arm, 5:4 sel.
// - Standby modes need crystal or resonator clock.
// - Interrupt wake adds four cycles past start-up.
// - Sleep never touches registers or SRAM.
// - Reset during sleep restarts at reset vector.
// - Software arms just before halt, clears after.
// - Idle stops only core and program clocks.
// - Idle wakes on any enabled interrupt.
// - Idle or noise mode starts converter conversion.
// - Noise mode also stops peripheral clock.
// - Noise mode wakes on listed sources only.
// - Power-down stops oscillator and all clocks.
// - Power-down wakes on resets, address, external lines.
// - Level wake source holds level long enough.
// - Power-down wake delayed by fuse start-up time.
// - Power-save adds async timer 2 wake.
// - Software prefers power-down without async timer.
// - Standby: power-down, oscillator on, six-cycle wake.
// - Extended standby: power-save, oscillator on, six cycles.
package smc_pkg;
	localparam logic [2:0] MODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_NOISE = 3'h1;
	localparam logic [2:0] MODE_DOWN = 3'h2;
	localparam logic [2:0] MODE_SAVE = 3'h3;
	localparam logic [2:0] MODE_STANDBY = 3'h6;
	localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;
	localparam int SEL_B2_POS = 7;
	localparam int ARM_POS = 6;
	localparam int SEL_B1_POS = 5;
	localparam int SEL_B0_POS = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'hF0;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h01;
	localparam logic [7:0] REG_CMD = 8'h02;
	localparam logic [3:0] CLK_SRC_EXT = 4'h0;
	localparam logic [3:0] CLK_SRC_RC_HI = 4'h4;
	localparam logic [3:0] CLK_SRC_CRYSTAL_LO = 4'h5;
	localparam logic [7:0] WAKE_HOLD_CYCLES = 8'h04;
	localparam logic [7:0] STANDBY_WAKE_CYCLES = 8'h06;
	localparam logic [7:0] DEFAULT_STARTUP_CYCLES = 8'h06;
	localparam int WAKE_SRC_W = 8;
	localparam int SRC_EXT_LEVEL01 = 0;
	localparam int SRC_EXT_LINE2 = 1;
	localparam int SRC_TWI_MATCH = 2;
	localparam int SRC_TIMER2 = 3;
	localparam int SRC_MEM_READY = 4;
	localparam int SRC_CONV_DONE = 5;
	localparam int SRC_OTHER_IO = 6;
	localparam int SRC_EXT_EDGE01 = 7;
	typedef enum logic [4:0] {
		SMC_RUN = 5'h01,
		SMC_SLEEP = 5'h02,
		SMC_STARTUP = 5'h04,
		SMC_HOLD = 5'h08,
		SMC_RESUME = 5'h10
	} smc_state_t;
endpackage : smc_pkg

// >>> rtl/smc_link_if.sv
// Interface joining the sleep mode controller and the core that drives it.
`timescale 1ns/10ps
interface smc_link_if;
	logic [7:0] ctrl_wdata;
	logic ctrl_write;
	logic [7:0] ctrl_rdata;
	logic halt_exec;
	logic irq_pending;
	logic core_clk_en;
	logic prog_clk_en;
	logic periph_clk_en;
	logic osc_en;
	logic conv_start;
	logic core_resume;
	logic core_irq_take;
	logic core_reset_vec;
	modport ctrl (
		input ctrl_wdata, ctrl_write, halt_exec, irq_pending,
		output ctrl_rdata, core_clk_en, prog_clk_en, periph_clk_en, osc_en, conv_start,
		output core_resume, core_irq_take, core_reset_vec
	);
	modport core (
		output ctrl_wdata, ctrl_write, halt_exec, irq_pending,
		input ctrl_rdata, core_clk_en, prog_clk_en, periph_clk_en, osc_en, conv_start,
		input core_resume, core_irq_take, core_reset_vec
	);
endinterface : smc_link_if

// >>> rtl/smc_controller.sv
// Sleep mode controller: control register, sleep state machine, clock gating and wake timing.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module smc_controller (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset,
	// Link to the core.
	smc_link_if.ctrl link,
	// Chip environment.
	input wire logic [3:0] clock_source_fuses,
	input wire logic [7:0] startup_cycles,
	input wire logic timer2_async_select,
	input wire logic conv_enabled,
	input wire logic [7:0] wake_src,
	input wire logic sys_reset_req,
	// Status.
	output logic asleep,
	output logic [2:0] active_mode
);
	typedef struct packed {
		smc_pkg::smc_state_t state;
		logic [7:0] ctrl;
		logic [2:0] mode;
		logic [7:0] count;
		logic core_clk_en;
		logic prog_clk_en;
		logic periph_clk_en;
		logic osc_en;
		logic conv_start;
		logic core_resume;
		logic core_irq_take;
		logic core_reset_vec;
		logic irq_wake;
		logic asleep;
	} smc_ctrl_t;

	smc_ctrl_t cur;
	smc_ctrl_t next_cur;

	function automatic logic crystal_source(input logic [3:0] src);
		crystal_source = (src >= smc_pkg::CLK_SRC_CRYSTAL_LO);
	endfunction : crystal_source

	function automatic logic [2:0] sel_field(input logic [7:0] r);
		sel_field = {r[smc_pkg::SEL_B2_POS], r[smc_pkg::SEL_B1_POS], r[smc_pkg::SEL_B0_POS]};
	endfunction : sel_field

	// Sources allowed to wake the core from each mode.
	function automatic logic wake_allowed(input logic [2:0] m, input logic [7:0] s, input logic async2);
		logic base;
		base = s[smc_pkg::SRC_EXT_LEVEL01] | s[smc_pkg::SRC_EXT_LINE2] | s[smc_pkg::SRC_TWI_MATCH];
		case (m)
			smc_pkg::MODE_IDLE: wake_allowed = |s;
			smc_pkg::MODE_NOISE: wake_allowed = base | s[smc_pkg::SRC_TIMER2] | s[smc_pkg::SRC_MEM_READY]
				| s[smc_pkg::SRC_CONV_DONE];
			smc_pkg::MODE_SAVE, smc_pkg::MODE_EXT_STANDBY: wake_allowed = base
				| (async2 & s[smc_pkg::SRC_TIMER2]);
			default: wake_allowed = base;
		endcase
	endfunction : wake_allowed

	always_comb begin
		logic [2:0] sel;
		logic stop_osc;
		sel = sel_field(cur.ctrl);
		stop_osc = 1'b0;
		next_cur = cur;
		next_cur.conv_start = 1'b0;
		next_cur.core_resume = 1'b0;
		next_cur.core_irq_take = 1'b0;
		next_cur.core_reset_vec = 1'b0;
		// The register file and SRAM are never touched here; only clock enables and controller state change.
		if (link.ctrl_write) begin
			next_cur.ctrl = link.ctrl_wdata & smc_pkg::CTRL_WRITE_MASK;
		end
		case (cur.state)
			smc_pkg::SMC_RUN: begin
				// Reserved codes and standby without a crystal fall back to a plain halt.
				if (link.halt_exec && cur.ctrl[smc_pkg::ARM_POS] && (sel[2:1] != 2'b10)
					&& (!sel[2] || crystal_source(clock_source_fuses))) begin
					next_cur.state = smc_pkg::SMC_SLEEP;
					next_cur.mode = sel;
					next_cur.core_clk_en = 1'b0;
					next_cur.prog_clk_en = 1'b0;
					next_cur.periph_clk_en = (sel == smc_pkg::MODE_IDLE);
					stop_osc = (sel == smc_pkg::MODE_DOWN) || (sel == smc_pkg::MODE_SAVE);
					next_cur.osc_en = !stop_osc;
					next_cur.conv_start = conv_enabled && !sel[2] && !sel[1];
				end
			end
			smc_pkg::SMC_SLEEP: begin
				if (wake_allowed(cur.mode, wake_src, timer2_async_select) && link.irq_pending) begin
					next_cur.state = smc_pkg::SMC_STARTUP;
					next_cur.osc_en = 1'b1;
					next_cur.irq_wake = 1'b1;
					// Only a stopped oscillator needs the fuse start-up time.
					if (cur.mode[2]) begin
						next_cur.count = smc_pkg::STANDBY_WAKE_CYCLES;
					end else if (cur.mode[1]) begin
						next_cur.count = startup_cycles;
					end else begin
						next_cur.count = 8'h01;
					end
				end
			end
			smc_pkg::SMC_STARTUP: begin
				if (cur.count <= 8'h01) begin
					next_cur.state = smc_pkg::SMC_HOLD;
					next_cur.periph_clk_en = 1'b1;
					next_cur.count = smc_pkg::WAKE_HOLD_CYCLES;
				end else begin
					next_cur.count = cur.count - 8'h01;
				end
			end
			smc_pkg::SMC_HOLD: begin
				if (cur.count <= 8'h01) begin
					next_cur.state = smc_pkg::SMC_RESUME;
					next_cur.core_clk_en = 1'b1;
					next_cur.prog_clk_en = 1'b1;
				end else begin
					next_cur.count = cur.count - 8'h01;
				end
			end
			smc_pkg::SMC_RESUME: begin
				next_cur.state = smc_pkg::SMC_RUN;
				next_cur.core_irq_take = cur.irq_wake;
				next_cur.core_resume = 1'b1;
				next_cur.irq_wake = 1'b0;
			end
			default: begin
				next_cur.state = smc_pkg::SMC_RUN;
			end
		endcase
		// A system reset ends any sleep and sends the core to the reset vector.
		if (sys_reset_req) begin
			next_cur.state = smc_pkg::SMC_RUN;
			next_cur.core_clk_en = 1'b1;
			next_cur.prog_clk_en = 1'b1;
			next_cur.periph_clk_en = 1'b1;
			next_cur.osc_en = 1'b1;
			next_cur.irq_wake = 1'b0;
			next_cur.count = 8'h00;
			next_cur.ctrl = smc_pkg::CTRL_RESET;
			next_cur.core_reset_vec = 1'b1;
			next_cur.core_resume = 1'b0;
			next_cur.core_irq_take = 1'b0;
		end
		// The sleep flag is registered from the next state so the status output never glitches.
		// It is taken after the reset override, so a reset clears it in the same cycle.
		next_cur.asleep = (next_cur.state != smc_pkg::SMC_RUN);
	end

	// All clocks run out of reset, so the core starts at once without a start-up delay.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cur <= '{
				state: smc_pkg::SMC_RUN,
				ctrl: smc_pkg::CTRL_RESET,
				mode: smc_pkg::MODE_IDLE,
				count: 8'h00,
				core_clk_en: 1'b1,
				prog_clk_en: 1'b1,
				periph_clk_en: 1'b1,
				osc_en: 1'b1,
				conv_start: 1'b0,
				core_resume: 1'b0,
				core_irq_take: 1'b0,
				core_reset_vec: 1'b0,
				irq_wake: 1'b0,
				asleep: 1'b0
			};
		end else begin
			cur <= next_cur;
		end
	end

	// Every link output is a plain copy of a state bit, so the core end sees no combinational paths.
	assign link.ctrl_rdata = cur.ctrl;
	assign link.core_clk_en = cur.core_clk_en;
	assign link.prog_clk_en = cur.prog_clk_en;
	assign link.periph_clk_en = cur.periph_clk_en;
	assign link.osc_en = cur.osc_en;
	assign link.conv_start = cur.conv_start;
	assign link.core_resume = cur.core_resume;
	assign link.core_irq_take = cur.core_irq_take;
	assign link.core_reset_vec = cur.core_reset_vec;
	assign asleep = cur.asleep;
	assign active_mode = cur.mode;
endmodule : smc_controller

// >>> rtl/smc_core_end.sv
// Core-side end: takes software orders through a register port and sequences arm, halt and disarm.
`timescale 1ns/10ps
module smc_core_end (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset,
	// Link to the controller.
	smc_link_if.core link,
	// Software register port.
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic write,
	input wire logic read,
	output logic [7:0] rdata,
	// Interrupt request from the system.
	input wire logic irq_in
);
	typedef struct packed {
		logic [7:0] wdata;
		logic write;
		logic halt;
		logic disarm;
		logic [7:0] rdata;
		logic woke_irq;
		logic woke_reset;
		logic halt_late;
	} smc_core_t;

	smc_core_t cur;
	smc_core_t next_cur;

	always_comb begin
		next_cur = cur;
		next_cur.write = 1'b0;
		next_cur.halt = 1'b0;
		next_cur.rdata = 8'h00;
		// Halt follows the arm write by one cycle so the controller sees the bit set.
		next_cur.halt_late = cur.halt;
		next_cur.woke_irq = cur.woke_irq | link.core_irq_take;
		next_cur.woke_reset = cur.woke_reset | link.core_reset_vec;
		if (cur.disarm) begin
			// Clear the arm bit straight after waking so a stray halt cannot sleep again.
			next_cur.wdata = link.ctrl_rdata & ~(8'h01 << smc_pkg::ARM_POS);
			next_cur.write = 1'b1;
			next_cur.disarm = 1'b0;
		end else if (write && addr == smc_pkg::REG_CTRL) begin
			next_cur.wdata = wdata;
			next_cur.write = 1'b1;
		end else if (write && addr == smc_pkg::REG_CMD) begin
			// Arm and halt in back-to-back cycles.
			next_cur.wdata = wdata | (8'h01 << smc_pkg::ARM_POS);
			next_cur.write = 1'b1;
			next_cur.halt = 1'b1;
		end
		if (link.core_resume) begin
			next_cur.disarm = 1'b1;
		end
		if (cur.write && cur.halt) begin
			next_cur.halt = 1'b0;
		end
		if (read) begin
			if (addr == smc_pkg::REG_CTRL) begin
				next_cur.rdata = link.ctrl_rdata;
			end else if (addr == smc_pkg::REG_STATUS) begin
				next_cur.rdata = {4'h0, link.core_clk_en, link.osc_en, cur.woke_reset, cur.woke_irq};
				next_cur.woke_irq = link.core_irq_take;
				next_cur.woke_reset = link.core_reset_vec;
			end else begin
				next_cur.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign link.ctrl_wdata = cur.wdata;
	assign link.ctrl_write = cur.write;
	assign link.halt_exec = cur.halt_late;
	assign link.irq_pending = irq_in;
	assign rdata = cur.rdata;
endmodule : smc_core_end

// >>> verif/smc_checker.sv
// Checker of the link between the sleep mode controller and its core end.
`timescale 1ns/10ps
module smc_checker (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset,
	// Link signals.
	input wire logic [7:0] ctrl_wdata,
	input wire logic ctrl_write,
	input wire logic [7:0] ctrl_rdata,
	input wire logic halt_exec,
	input wire logic core_clk_en,
	input wire logic prog_clk_en,
	input wire logic periph_clk_en,
	input wire logic osc_en,
	input wire logic core_resume,
	input wire logic core_irq_take,
	input wire logic core_reset_vec
);
	logic [2:0] md;
	assign md = {ctrl_rdata[7], ctrl_rdata[5:4]};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	AST_ENTRY_ARMED: assert property ($fell(core_clk_en) |-> $past(halt_exec) && $past(ctrl_rdata[6]))
		else $error("clocks stopped without armed halt");
	AST_HALT_DISARMED: assert property (halt_exec && !ctrl_rdata[6] |=> core_clk_en)
		else $error("disarmed halt stopped the core");
	AST_IDLE_CLOCKS: assert property ($fell(core_clk_en) && md == smc_pkg::MODE_IDLE |->
		!prog_clk_en && periph_clk_en && osc_en) else $error("idle clock set wrong");
	AST_NOISE_CLOCKS: assert property ($fell(core_clk_en) && md == smc_pkg::MODE_NOISE |->
		!prog_clk_en && !periph_clk_en && osc_en) else $error("noise clock set wrong");
	AST_DOWN_CLOCKS: assert property ($fell(core_clk_en) && md[2:1] == 2'h1 |->
		!periph_clk_en && !osc_en) else $error("power-down clock set wrong");
	AST_STANDBY_CLOCKS: assert property ($fell(core_clk_en) && md[2] |->
		!periph_clk_en && osc_en) else $error("standby clock set wrong");
	AST_WAKE_PULSE: assert property ($rose(core_clk_en) |-> ##[0:1] (core_resume || core_reset_vec))
		else $error("wake without resume or vector");
	AST_RESUME_OR_VECTOR: assert property (core_irq_take |-> core_resume && !core_reset_vec)
		else $error("interrupt taken with reset vector");
	AST_DISARM_AFTER_WAKE: assert property (core_resume |-> ##[1:3] (ctrl_write && !ctrl_wdata[6]))
		else $error("arm bit not cleared after wake");
	AST_CTRL_WRITE: assert property (ctrl_write |=> ctrl_rdata == {$past(ctrl_wdata[7:4]), 4'h0})
		else $error("control register write lost");
endmodule : smc_checker

// >>> verif/sleep_mode_controller_test.sv
// Self-checking bench for the sleep mode controller and its core end.
`timescale 1ns/10ps
module sleep_mode_controller_test;
	logic ref_clk, reset, write, read, rd_q, irq_in, t2_async, conv_enabled, sys_reset_req, asleep;
	logic [7:0] addr, wdata, rdata, startup_cycles, wake_src, d;
	logic [3:0] clock_source_fuses;
	logic [2:0] active_mode;
	logic [7:0] exp_q[$];
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int convs = 0;
	int waits = 0;
	smc_link_if smc_link_if_inst();
	smc_controller smc_controller_inst(.ref_clk(ref_clk), .reset(reset), .link(smc_link_if_inst),
		.clock_source_fuses(clock_source_fuses), .startup_cycles(startup_cycles), .timer2_async_select(t2_async),
		.conv_enabled(conv_enabled), .wake_src(wake_src), .sys_reset_req(sys_reset_req), .asleep(asleep),
		.active_mode(active_mode));
	smc_core_end smc_core_end_inst(.ref_clk(ref_clk), .reset(reset), .link(smc_link_if_inst), .addr(addr),
		.wdata(wdata), .write(write), .read(read), .rdata(rdata), .irq_in(irq_in));
	smc_checker smc_checker_inst(.ref_clk(ref_clk), .reset(reset), .ctrl_wdata(smc_link_if_inst.ctrl_wdata),
		.ctrl_write(smc_link_if_inst.ctrl_write), .ctrl_rdata(smc_link_if_inst.ctrl_rdata),
		.halt_exec(smc_link_if_inst.halt_exec), .core_clk_en(smc_link_if_inst.core_clk_en),
		.prog_clk_en(smc_link_if_inst.prog_clk_en), .periph_clk_en(smc_link_if_inst.periph_clk_en),
		.osc_en(smc_link_if_inst.osc_en), .core_resume(smc_link_if_inst.core_resume),
		.core_irq_take(smc_link_if_inst.core_irq_take), .core_reset_vec(smc_link_if_inst.core_reset_vec));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task close_out;
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	// Strobes drop for one idle cycle so no task assigns a strobe twice in one time step.
	task acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] dat);
		write <= w;
		read <= r;
		addr <= a;
		wdata <= dat;
		@(posedge ref_clk);
		write <= 1'b0;
		read <= 1'b0;
		@(posedge ref_clk);
	endtask : acc
	task rd(input logic [7:0] a, input logic [7:0] exp);
		exp_q.push_back(exp);
		acc(1'b0, 1'b1, a, 8'h00);
	endtask : rd
	task sleep_cmd(input logic [2:0] m, input logic ok);
		int n;
		n = 0;
		acc(1'b1, 1'b0, smc_pkg::REG_CMD, {m[2], 1'b1, m[1:0], 4'h0});
		while (asleep !== 1'b1 && n < 8) begin
			@(posedge ref_clk);
			n++;
		end
		check({7'h00, asleep}, {7'h00, ok}, "asleep");
	endtask : sleep_cmd
	task nap(input logic [2:0] m, input logic [7:0] bad, input logic [7:0] good, input int minc);
		int n;
		n = 0;
		sleep_cmd(m, 1'b1);
		check({5'h00, active_mode}, {5'h00, m}, "active_mode");
		wake_src <= bad;
		irq_in <= 1'b1;
		repeat (12) @(posedge ref_clk);
		check({7'h00, asleep}, 8'h01, "asleep on refused source");
		wake_src <= good;
		while (smc_link_if_inst.core_resume !== 1'b1 && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
		check({7'h00, n >= minc && n < 300}, 8'h01, "wake delay");
		wake_src <= 8'h00;
		irq_in <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rd(smc_pkg::REG_CTRL, {m[2], 1'b0, m[1:0], 4'h0});
	endtask : nap
	always @(posedge ref_clk) begin
		rd_q <= read;
		if (rd_q === 1'b1)
			check(rdata, exp_q.pop_front(), "rdata");
		if (smc_link_if_inst.conv_start === 1'b1)
			convs++;
		cycles++;
		if (cycles == 6000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		reset = 1'b1;
		{write, read, irq_in, t2_async, sys_reset_req} = 5'h00;
		{addr, wdata, wake_src} = 24'h000000;
		conv_enabled = 1'b1;
		clock_source_fuses = smc_pkg::CLK_SRC_CRYSTAL_LO;
		void'($urandom(32'h230647ed));
		startup_cycles = 8'($urandom_range(9, 2));
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		rd(smc_pkg::REG_CTRL, smc_pkg::CTRL_RESET);
		d = 8'($urandom);
		acc(1'b1, 1'b0, smc_pkg::REG_CTRL, d);
		rd(smc_pkg::REG_CTRL, d & smc_pkg::CTRL_WRITE_MASK);
		nap(smc_pkg::MODE_IDLE, 8'h00, 8'h40, 5);
		check(8'(convs), 8'h01, "conversions");
		rd(smc_pkg::REG_STATUS, 8'h0D);
		rd(smc_pkg::REG_STATUS, 8'h0C);
		nap(smc_pkg::MODE_NOISE, 8'hC0, 8'h20, 5);
		nap(smc_pkg::MODE_DOWN, 8'hF8, 8'h01, startup_cycles + 4);
		check(8'(convs), 8'h02, "conversions");
		t2_async <= 1'b1;
		nap(smc_pkg::MODE_SAVE, 8'hF0, 8'h08, startup_cycles + 4);
		nap(smc_pkg::MODE_STANDBY, 8'hF8, 8'h02, 10);
		nap(smc_pkg::MODE_EXT_STANDBY, 8'hF0, 8'h08, 10);
		sleep_cmd(3'h4, 1'b0);
		sleep_cmd(3'h5, 1'b0);
		clock_source_fuses <= smc_pkg::CLK_SRC_RC_HI;
		sleep_cmd(smc_pkg::MODE_STANDBY, 1'b0);
		sleep_cmd(smc_pkg::MODE_EXT_STANDBY, 1'b0);
		sleep_cmd(smc_pkg::MODE_DOWN, 1'b1);
		sys_reset_req <= 1'b1;
		while (smc_link_if_inst.core_reset_vec !== 1'b1 && waits < 300) begin
			@(posedge ref_clk);
			waits++;
		end
		check({7'h00, waits < 300}, 8'h01, "reset vector");
		sys_reset_req <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rd(smc_pkg::REG_STATUS, 8'h0F);
		repeat (2) @(posedge ref_clk);
		close_out();
	end
endmodule : sleep_mode_controller_test
